/* File: rtl/rtpcs_top.sv */
// rail trim pwm generator with i2c-loaded parameter store
// assumes an external byte-wide nonvolatile store with a ready/valid handshake,
// and i2c pins already open-drain resolved outside
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
module rtpcs_top
  import rtpcs_pkg::*;
#(
  parameter int NRAIL = RTPCS_NRAIL
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_b_out,
  input wire logic nv_rdy_in,
  input wire logic [7:0] nv_rdata_in,
  output logic nv_req_out,
  output logic nv_we_out,
  output logic [4:0] nv_addr_out,
  output logic [7:0] nv_wdata_out,
  output logic [NRAIL-1:0] trim_pwm_out
);
  if (NRAIL < 1 || NRAIL > RTPCS_NRAIL) begin : g_chk
    $error("rtpcs_top: NRAIL must be 1..4");
  end
  localparam int NB = RTPCS_NBYTE;
  // 48 MHz from 20 MHz: phase accumulator gives fractional steps per core clock
  localparam int PH_W = 16;
  // worked in 64 bits: the product would overflow a 32-bit int
  localparam logic [PH_W-1:0] PH_FRAC =
    PH_W'(64'(RTPCS_PWM_HZ % RTPCS_CORE_HZ) * 64'd65536 / 64'(RTPCS_CORE_HZ));
  localparam logic [8:0] PH_WHOLE = 9'(RTPCS_PWM_HZ / RTPCS_CORE_HZ);

  typedef enum logic [4:0] {
    NV_IDLE = 5'h01, NV_MARK = 5'h02, NV_LOAD = 5'h04, NV_SAVE = 5'h08, NV_RUN = 5'h10
  } rtpcs_nv_t;
  typedef enum logic [3:0] {
    I2_IDLE = 4'h1, I2_ADDR = 4'h2, I2_ACK = 4'h4, I2_DATA = 4'h8
  } rtpcs_i2_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [RTPCS_NRAIL-1:0][15:0] meas;
    logic [RTPCS_NRAIL-1:0][15:0] nom;
    logic [RTPCS_NRAIL-1:0][7:0] duty;
    logic [PH_W-1:0] phase;
    logic [RTPCS_NRAIL-1:0][7:0] cnt;
    logic [RTPCS_NRAIL-1:0] pwm;
    logic [NB-1:0][7:0] act;
    logic [NB-1:0][7:0] rx;
    logic [4:0] rx_cnt;
    logic rx_done;
    rtpcs_nv_t nv;
    logic [4:0] nv_ix;
    logic nv_req;
    logic nv_we;
    logic [7:0] nv_wd;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic scl_q;
    logic sda_q;
    rtpcs_i2_t i2;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic sda_oe_b;
    logic addr_ok;
    logic [31:0] rd;
    logic ack;
  } rtpcs_st_t;

  rtpcs_st_t s_r;
  rtpcs_st_t s_nxt;

  function automatic logic [7:0] dflt(input int i);
    logic [7:0] v;
    v = 8'h00;
    if (i == RTPCS_POS_MODE) v = RTPCS_RST_MODE;
    else if (i < RTPCS_POS_UV) begin
      case ((i - RTPCS_POS_DELAY) % 4)
        0: v = RTPCS_RST_SLOT[15:8];
        1: v = RTPCS_RST_SLOT[7:0];
        2: v = RTPCS_RST_RAMP[15:8];
        default: v = RTPCS_RST_RAMP[7:0];
      endcase
    end else if (i == RTPCS_POS_UV) v = RTPCS_RST_UV;
    else if (i == RTPCS_POS_OV) v = RTPCS_RST_OV;
    else if (i < RTPCS_POS_SYNC) v = RTPCS_RST_TRIM;
    else v = RTPCS_RST_SYNC;
    return v;
  endfunction

  always_comb begin
    logic [PH_W:0] ph_sum;
    logic [8:0] steps;
    logic rx_set;
    logic [31:0] tol;
    logic scl_f;
    logic sda_f;
    logic [4:0] ri;
    ph_sum = '0;
    steps = '0;
    rx_set = 1'b0;
    tol = '0;
    scl_f = 1'b0;
    sda_f = 1'b0;
    ri = '0;
    s_nxt = s_r;
    s_nxt.ack = 1'b0;

    ///////////////////////////////////////////////////////////////////////////
    // pwm: counters advance by 48 MHz worth of steps each core clock
    ph_sum = {1'b0, s_r.phase} + {1'b0, PH_FRAC};
    s_nxt.phase = ph_sum[PH_W-1:0];
    steps = PH_WHOLE + {8'h00, ph_sum[PH_W]};
    for (int r = 0; r < RTPCS_NRAIL; r++) begin
      s_nxt.cnt[r] = s_r.cnt[r] + steps[7:0];
      // zero duty never drives high, giving the highest regulator output
      s_nxt.pwm[r] = (s_nxt.cnt[r] < s_r.duty[r]);
    end

    ///////////////////////////////////////////////////////////////////////////
    // trim: tolerance = nominal * trim% / 100, only once parameters are loaded
    for (int r = 0; r < RTPCS_NRAIL; r++) begin
      tol = 32'(s_r.nom[r]) * 32'(s_r.act[RTPCS_POS_TRIM + r]) / 32'd100;
      if (s_r.ctrl[RTPCS_CTRL_TRIM_EN] && s_r.nv == NV_RUN && s_r.ack) begin
        if (32'(s_r.meas[r]) > 32'(s_r.nom[r]) + tol) begin
          if (s_r.duty[r] != 8'hFF) s_nxt.duty[r] = s_r.duty[r] + 8'h01;
        end else if (32'(s_r.meas[r]) + tol < 32'(s_r.nom[r])) begin
          if (s_r.duty[r] != 8'h00) s_nxt.duty[r] = s_r.duty[r] - 8'h01;
        end
      end
    end

    ///////////////////////////////////////////////////////////////////////////
    // i2c slave, write only; three-stage sync, change taken when stages 2 and 3 agree
    s_nxt.scl_s = {s_r.scl_s[1:0], scl_in};
    s_nxt.sda_s = {s_r.sda_s[1:0], sda_in};
    scl_f = (s_r.scl_s[1] == s_r.scl_s[2]) ? s_r.scl_s[2] : s_r.scl_q;
    sda_f = (s_r.sda_s[1] == s_r.sda_s[2]) ? s_r.sda_s[2] : s_r.sda_q;
    s_nxt.scl_q = scl_f;
    s_nxt.sda_q = sda_f;
    if (s_r.scl_q && scl_f && s_r.sda_q && !sda_f) begin // start
      s_nxt.i2 = I2_ADDR;
      s_nxt.bitc = '0;
      s_nxt.rx_cnt = '0;
      s_nxt.addr_ok = 1'b0;
    end else if (s_r.scl_q && scl_f && !s_r.sda_q && sda_f) begin // stop
      // a whole image ending in the sync flag counts as a new parameter set
      // rx_cnt counts the write address byte too, so a full image ends at NB + 1
      rx_set = s_r.addr_ok && s_r.rx_cnt == 5'(NB + 1);
      if (rx_set) s_nxt.rx_done = 1'b1;
      s_nxt.i2 = I2_IDLE;
      s_nxt.sda_oe_b = 1'b1;
    end else if (!s_r.scl_q && scl_f) begin // rising scl: sample
      if (s_r.i2 == I2_ADDR || s_r.i2 == I2_DATA) begin
        s_nxt.sh = {s_r.sh[6:0], sda_f};
        s_nxt.bitc = s_r.bitc + 4'h1;
      end
    end else if (s_r.scl_q && !scl_f) begin // falling scl: drive ack
      s_nxt.sda_oe_b = 1'b1;
      case (s_r.i2)
        I2_ADDR: if (s_r.bitc == 4'd8) begin
          if (s_r.sh[7:1] == 7'(RTPCS_I2C_ADDR) && !s_r.sh[0]) begin
            s_nxt.addr_ok = 1'b1;
            s_nxt.sda_oe_b = 1'b0;
            s_nxt.i2 = I2_ACK;
          end else s_nxt.i2 = I2_IDLE;
        end
        I2_DATA: if (s_r.bitc == 4'd8) begin
          // first byte is the write address (0), then the image bytes
          if (s_r.rx_cnt != 5'h1F) begin
            if (s_r.rx_cnt != 5'h00 && s_r.rx_cnt <= 5'(NB))
              s_nxt.rx[s_r.rx_cnt - 5'h01] = s_r.sh;
            // one step past a full image marks extra bytes, so that stop saves nothing
            if (s_r.rx_cnt <= 5'(NB + 1)) s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
          end
          s_nxt.sda_oe_b = 1'b0;
          s_nxt.i2 = I2_ACK;
        end
        I2_ACK: begin
          s_nxt.bitc = '0;
          s_nxt.i2 = I2_DATA;
        end
        default: ;
      endcase
    end

    ///////////////////////////////////////////////////////////////////////////
    // storage: byte 0 is the valid mark, bytes 1..NB the image
    s_nxt.nv_req = 1'b0;
    case (s_r.nv)
      NV_IDLE: begin
        s_nxt.nv_req = 1'b1;
        s_nxt.nv_we = 1'b0;
        s_nxt.nv_ix = '0;
        s_nxt.nv = NV_MARK;
      end
      NV_MARK: if (nv_rdy_in) begin
        if (nv_rdata_in == RTPCS_VALID_MARK) begin
          s_nxt.nv = NV_LOAD;
          s_nxt.nv_ix = 5'h01;
          s_nxt.nv_req = 1'b1;
        end else begin
          for (int i = 0; i < NB; i++) s_nxt.act[i] = dflt(i);
          for (int i = 0; i < NB; i++) s_nxt.rx[i] = dflt(i);
          s_nxt.nv = NV_SAVE;
          s_nxt.nv_ix = 5'h01;
          s_nxt.nv_we = 1'b1;
          s_nxt.nv_wd = dflt(0);
          s_nxt.nv_req = 1'b1;
        end
      end else s_nxt.nv_req = 1'b1;
      NV_LOAD: begin
        s_nxt.nv_req = 1'b1;
        if (nv_rdy_in) begin
          s_nxt.act[s_r.nv_ix - 5'h01] = nv_rdata_in;
          if (s_r.nv_ix == 5'(NB)) begin
            s_nxt.nv = NV_RUN;
            s_nxt.nv_req = 1'b0;
          end else s_nxt.nv_ix = s_r.nv_ix + 5'h01;
        end
      end
      NV_SAVE: begin
        // mark is written last but never cleared first, so only a torn first save falls back to defaults
        s_nxt.nv_req = 1'b1;
        if (nv_rdy_in) begin
          if (s_r.nv_ix == 5'h00) begin
            s_nxt.nv = NV_RUN;
            s_nxt.nv_req = 1'b0;
            s_nxt.nv_we = 1'b0;
          end else if (s_r.nv_ix == 5'(NB)) begin
            s_nxt.nv_ix = 5'h00;
            s_nxt.nv_wd = RTPCS_VALID_MARK;
          end else begin
            s_nxt.nv_ix = s_r.nv_ix + 5'h01;
            ri = s_r.nv_ix;
            s_nxt.nv_wd = s_r.rx[ri];
          end
        end
      end
      NV_RUN: if (s_r.rx_done) begin
        // rx image goes only to storage; act is untouched until restart
        // a stop in this very cycle keeps the flag set
        s_nxt.rx_done = rx_set;
        s_nxt.nv = NV_SAVE;
        s_nxt.nv_ix = 5'h01;
        s_nxt.nv_we = 1'b1;
        s_nxt.nv_wd = s_r.rx[0];
        s_nxt.nv_req = 1'b1;
      end
      default: s_nxt.nv = NV_IDLE;
    endcase
    if (s_r.nv == NV_SAVE && s_nxt.nv == NV_SAVE && s_nxt.nv_ix == 5'h00 && !nv_rdy_in)
      s_nxt.nv_wd = s_r.nv_wd;

    ///////////////////////////////////////////////////////////////////////////
    // wishbone classic slave, ack one cycle after the strobe, dropped between
    if (wb_cyc_in && wb_stb_in && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rd = '0;
      ri = 5'(wb_adr_in[3:2]);
      if (wb_adr_in == RTPCS_OFS_CTRL) begin
        s_nxt.rd = s_r.ctrl;
        if (wb_we_in && wb_sel_in[0]) s_nxt.ctrl[7:0] = wb_dat_in[7:0];
      end else if (wb_adr_in == RTPCS_OFS_STAT) begin
        s_nxt.rd = {27'h0, s_r.nv};
      end else if (wb_adr_in[7:4] == RTPCS_OFS_MEAS[7:4]) begin
        s_nxt.rd = {16'h0, s_r.meas[ri[1:0]]};
        if (wb_we_in && wb_sel_in[0]) s_nxt.meas[ri[1:0]][7:0] = wb_dat_in[7:0];
        if (wb_we_in && wb_sel_in[1]) s_nxt.meas[ri[1:0]][15:8] = wb_dat_in[15:8];
      end else if (wb_adr_in[7:4] == RTPCS_OFS_NOM[7:4]) begin
        s_nxt.rd = {16'h0, s_r.nom[ri[1:0]]};
        if (wb_we_in && wb_sel_in[0]) s_nxt.nom[ri[1:0]][7:0] = wb_dat_in[7:0];
        if (wb_we_in && wb_sel_in[1]) s_nxt.nom[ri[1:0]][15:8] = wb_dat_in[15:8];
      end else if (wb_adr_in[7:4] == RTPCS_OFS_DUTY[7:4]) begin
        s_nxt.rd = {24'h0, s_r.duty[ri[1:0]]};
        if (wb_we_in && wb_sel_in[0]) s_nxt.duty[ri[1:0]] = wb_dat_in[7:0];
      end else if (wb_adr_in >= RTPCS_OFS_ACT && wb_adr_in < RTPCS_OFS_ACT + 8'(NB / 4 * 4)) begin
        ri = 5'((wb_adr_in - RTPCS_OFS_ACT) >> 2);
        s_nxt.rd = {s_r.act[ri * 4 + 3], s_r.act[ri * 4 + 2],
                    s_r.act[ri * 4 + 1], s_r.act[ri * 4]};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_r <= '0;
      s_r.ctrl <= RTPCS_RST_CTRL;
      s_r.nv <= NV_IDLE;
      s_r.i2 <= I2_IDLE;
      s_r.sda_oe_b <= 1'b1;
      s_r.scl_s <= 3'b111;
      s_r.sda_s <= 3'b111;
      s_r.scl_q <= 1'b1;
      s_r.sda_q <= 1'b1;
      for (int r = 0; r < RTPCS_NRAIL; r++) s_r.duty[r] <= RTPCS_RST_DUTY;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign wb_dat_out = s_r.rd;
  assign wb_ack_out = s_r.ack;
  assign sda_oe_b_out = s_r.sda_oe_b;
  assign nv_req_out = s_r.nv_req;
  assign nv_we_out = s_r.nv_we;
  assign nv_addr_out = s_r.nv_ix;
  assign nv_wdata_out = s_r.nv_wd;
  assign trim_pwm_out = s_r.pwm[NRAIL-1:0];
endmodule

/* File: shared/rtpcs_pkg.sv */
// constants for the rail trim pwm and parameter store block
// assumes one 20 MHz core clock and a 48 MHz pwm enable derived from it
//
// How it works
// - pwm counter steps at 48 MHz rate
// - eight-bit pwm, 256 clocks, 187.5 kHz
// - out of tolerance rail gets duty adjusted
// - more duty lowers voltage, less raises
// - zero duty gives highest output voltage
// - each rail keeps its own trim percentage
// - device is i2c slave, host writes parameters
// - store mode, delays, thresholds, trim per rail
// - defaults used only first boot, then saved
// - new parameter set is saved to storage
// - every startup with a valid mark loads parameters from storage
// - new parameters take effect after restart only
package rtpcs_pkg;
  localparam int RTPCS_NRAIL = 4;
  // parameter image: mode, 4x(slot hi, slot lo, ramp hi, ramp lo), uv, ov, 4x trim, sync
  localparam int RTPCS_NBYTE = 24;
  localparam int RTPCS_POS_MODE = 0;
  localparam int RTPCS_POS_DELAY = 1;
  localparam int RTPCS_POS_UV = 17;
  localparam int RTPCS_POS_OV = 18;
  localparam int RTPCS_POS_TRIM = 19;
  localparam int RTPCS_POS_SYNC = 23;
  localparam logic [7:0] RTPCS_RST_MODE = 8'h01;
  localparam logic [15:0] RTPCS_RST_SLOT = 16'h0064;
  localparam logic [15:0] RTPCS_RST_RAMP = 16'h000A;
  localparam logic [7:0] RTPCS_RST_UV = 8'h04;
  localparam logic [7:0] RTPCS_RST_OV = 8'h04;
  localparam logic [7:0] RTPCS_RST_TRIM = 8'h01;
  localparam logic [7:0] RTPCS_RST_SYNC = 8'h01;
  localparam logic [7:0] RTPCS_RST_DUTY = 8'h00;
  // marker byte in storage telling that a valid image was written once
  localparam logic [7:0] RTPCS_VALID_MARK = 8'hA5;
  // wishbone byte offsets
  localparam logic [7:0] RTPCS_OFS_CTRL = 8'h00;
  localparam logic [7:0] RTPCS_OFS_STAT = 8'h04;
  localparam logic [7:0] RTPCS_OFS_MEAS = 8'h10;
  localparam logic [7:0] RTPCS_OFS_NOM = 8'h20;
  localparam logic [7:0] RTPCS_OFS_DUTY = 8'h30;
  localparam logic [7:0] RTPCS_OFS_ACT = 8'h40;
  localparam int RTPCS_CTRL_TRIM_EN = 0;
  localparam logic [31:0] RTPCS_RST_CTRL = 32'h0000_0001;
  // timing: pwm source and core clock
  localparam int RTPCS_PWM_HZ = 48_000_000;
  localparam int RTPCS_CORE_HZ = 20_000_000;
  localparam int RTPCS_PWM_BITS = 8;
  localparam int RTPCS_I2C_ADDR = 7'h28;
endpackage

/* File: tb/rtpcs_nv_model.sv */
// storage partner: 32 erased bytes, each request answered one cycle later
// assumes the block holds req, we, addr and wdata until it sees rdy
`timescale 1ns/1ps
module rtpcs_nv_model (
  input wire logic clk_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [4:0] addr_in,
  input wire logic [7:0] wdata_in,
  output logic rdy_out,
  output logic [7:0] rdata_out
);
  logic [7:0] mem [32];
  logic [7:0] last_r;
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    rdy_out = 1'b0;
    last_r = 8'h00;
  end
  always @(posedge clk_in) begin
    rdy_out <= req_in && !rdy_out;
    if (req_in && rdy_out) last_r <= mem[addr_in];
    if (req_in && rdy_out && we_in) mem[addr_in] <= wdata_in;
  end
  // outside an answer the data lines show garbage, never the old byte
  assign rdata_out = rdy_out ? mem[addr_in] : ~last_r;
endmodule

/* File: tb/rtpcs_chk.sv */
// port checker for the trim and parameter store block
// assumes one clock domain and the storage handshake of the partner model
`timescale 1ns/1ps
module rtpcs_chk
  import rtpcs_pkg::*;
#(
  parameter int NRAIL = RTPCS_NRAIL
) (
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic scl_in,
  input wire logic sda_oe_b_out,
  input wire logic nv_rdy_in,
  input wire logic nv_req_out,
  input wire logic nv_we_out,
  input wire logic [4:0] nv_addr_out,
  input wire logic [7:0] nv_wdata_out,
  input wire logic [NRAIL-1:0] trim_pwm_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////
  ack_one_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_latency_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("access not acked next cycle");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  unmapped_zero_a: assert property (wb_ack_out && $past(!wb_we_in && wb_adr_in >= 8'h58)
    |-> wb_dat_out == 32'h0000_0000)
    else $error("unmapped read not zero");
  nv_hold_a: assert property (nv_req_out && !nv_rdy_in |=> nv_req_out && $stable(nv_addr_out)
    && $stable(nv_we_out) && $stable(nv_wdata_out))
    else $error("storage request changed before answer");
  nv_mark_a: assert property (nv_req_out && nv_we_out && nv_addr_out == 5'h00
    |-> nv_wdata_out == RTPCS_VALID_MARK)
    else $error("bad valid marker");
  nv_range_a: assert property (nv_req_out |-> nv_addr_out <= 5'h18)
    else $error("storage address beyond image");
  sda_low_a: assert property ($fell(sda_oe_b_out) |-> !scl_in)
    else $error("ack driven while clock high");
  sda_hold_a: assert property ($rose(scl_in) && !sda_oe_b_out |=> !sda_oe_b_out [*8])
    else $error("ack released while clock high");
  ////////////////////////////////////////////////////////////////////////
  read_c: cover property (wb_ack_out && !wb_we_in);
  save_c: cover property (nv_req_out && nv_we_out && nv_rdy_in);
  i2c_ack_c: cover property ($fell(sda_oe_b_out));
  pwm_c: cover property ($rose(trim_pwm_out[0]));
endmodule

/* File: tb/testbench.sv */
// bench: wishbone and i2c host tasks around the block and a storage model
// assumes storage starts erased, so the first boot takes the defaults
`timescale 1ns/1ps
module testbench;
  import rtpcs_pkg::*;
  localparam int NRAIL = RTPCS_NRAIL;
  logic core_clk_in, rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, scl_in, sda_drv;
  logic [7:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, d, d1;
  logic wb_ack_out, sda_oe_b_out, nv_rdy_in, nv_req_out, nv_we_out;
  logic [7:0] nv_rdata_in, nv_wdata_out;
  logic [4:0] nv_addr_out;
  logic [NRAIL-1:0] trim_pwm_out;
  wire logic sda_in;
  int mismatches = 0, samples_checked = 0, hi, rises;
  // pull-up on the data line
  assign sda_in = sda_drv & sda_oe_b_out;
  rtpcs_top #(.NRAIL(NRAIL)) i_dut (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
    .wb_ack_out(wb_ack_out), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_b_out(sda_oe_b_out),
    .nv_rdy_in(nv_rdy_in), .nv_rdata_in(nv_rdata_in), .nv_req_out(nv_req_out),
    .nv_we_out(nv_we_out), .nv_addr_out(nv_addr_out), .nv_wdata_out(nv_wdata_out),
    .trim_pwm_out(trim_pwm_out));
  rtpcs_nv_model i_nv (.clk_in(core_clk_in), .req_in(nv_req_out), .we_in(nv_we_out),
    .addr_in(nv_addr_out), .wdata_in(nv_wdata_out), .rdy_out(nv_rdy_in), .rdata_out(nv_rdata_in));
  initial begin
    core_clk_in = 1'b0;
    forever #25 core_clk_in = ~core_clk_in;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
      output logic [31:0] rd);
    @(posedge core_clk_in);
    {wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} <= {2'b11, we, adr, dat};
    // no cycle count assumed: only the watchdog ends a hung wait
    do @(posedge core_clk_in);
    while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    {wb_cyc_in, wb_stb_in} <= 2'b00;
  endtask
  // image byte i, new host set or built-in defaults
  function automatic logic [7:0] img(input bit nw, input int i);
    if (i == RTPCS_POS_MODE) return nw ? 8'h02 : RTPCS_RST_MODE;
    if (i < RTPCS_POS_UV) begin
      case ((i - 1) % 4)
        0: return nw ? 8'h03 : RTPCS_RST_SLOT[15:8];
        1: return nw ? 8'hE8 : RTPCS_RST_SLOT[7:0];
        2: return nw ? 8'h01 : RTPCS_RST_RAMP[15:8];
        default: return nw ? 8'hF4 : RTPCS_RST_RAMP[7:0];
      endcase
    end
    if (i == RTPCS_POS_UV) return nw ? 8'h05 : RTPCS_RST_UV;
    if (i == RTPCS_POS_OV) return nw ? 8'h06 : RTPCS_RST_OV;
    if (i < RTPCS_POS_SYNC) return nw ? 8'(i - 16) : RTPCS_RST_TRIM;
    return RTPCS_RST_SYNC;
  endfunction
  task automatic check_img(input bit nw, input bit act);
    for (int w = 0; w < 6; w++) begin
      wb(1'b0, RTPCS_OFS_ACT + 8'(4 * w), 32'h0, d);
      if (act) check(d, {img(nw, 4*w+3), img(nw, 4*w+2), img(nw, 4*w+1), img(nw, 4*w)});
    end
    for (int i = 0; i < 24; i++) if (!act) check(i_nv.mem[i + 1], img(nw, i));
    if (!act) check(i_nv.mem[0], RTPCS_VALID_MARK);
  endtask
  task automatic boot();
    d = '0;
    rst_b_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    for (int n = 0; n < 300 && d[4:0] !== 5'h10; n++) wb(1'b0, RTPCS_OFS_STAT, 32'h0, d);
    check(d[4:0], 5'h10);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask
  task automatic i2c_bit(input logic b, input bit ack);
    sda_drv <= b;
    wait_n(12);
    if (ack) check(sda_oe_b_out, 1'b0);
    scl_in <= 1'b1;
    wait_n(12);
    scl_in <= 1'b0;
    wait_n(3);
  endtask
  task automatic i2c_byte(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) i2c_bit(b[k], 1'b0);
    i2c_bit(1'b1, 1'b1);
  endtask
  task automatic count_pwm(input int n);
    logic prev;
    prev = trim_pwm_out[0];
    {hi, rises} = 0;
    repeat (n) begin
      @(posedge core_clk_in);
      hi += trim_pwm_out[0];
      rises += (trim_pwm_out[0] && !prev);
      prev = trim_pwm_out[0];
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in} = '0;
    {scl_in, sda_drv, wb_sel_in} = 6'h3F;
    boot();
    check_img(1'b0, 1'b1);
    check_img(1'b0, 1'b0);
    wb(1'b0, RTPCS_OFS_CTRL, 32'h0, d);
    check(d, RTPCS_RST_CTRL);
    wb(1'b1, 8'h80, 32'h1234_5678, d);
    wb(1'b0, 8'h80, 32'h0, d);
    check(d, 32'h0);
    wb(1'b1, RTPCS_OFS_NOM, 32'd1000, d);
    wb(1'b1, RTPCS_OFS_MEAS, 32'd1000, d);
    wb(1'b1, RTPCS_OFS_DUTY, 32'hFD, d);
    // 1010 sits exactly on the 1% limit, so no step yet
    wb(1'b1, RTPCS_OFS_MEAS, 32'd1010, d);
    wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d);
    check(d, 32'hFD);
    wb(1'b1, RTPCS_OFS_MEAS, 32'd1011, d);
    repeat (4) wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d);
    check(d, 32'hFF);
    wb(1'b1, RTPCS_OFS_MEAS, 32'd989, d);
    wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d1);
    wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d);
    check(d1, 32'hFE);
    check(d, 32'hFD);
    repeat (258) wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d);
    check(d, 32'h0);
    wb(1'b1, RTPCS_OFS_CTRL, 32'h0, d);
    wb(1'b1, RTPCS_OFS_DUTY, 32'h40, d);
    wb(1'b0, RTPCS_OFS_DUTY, 32'h0, d);
    check(d, 32'h40);
    // 1067 core clocks are ten pwm periods at 48 MHz counting
    count_pwm(1067);
    check(hi >= 258 && hi <= 276, 1'b1);
    check(rises >= 9 && rises <= 11, 1'b1);
    check(32'(trim_pwm_out[NRAIL-1:1]), 32'h0);
    wb(1'b1, RTPCS_OFS_DUTY, 32'h0, d);
    count_pwm(300);
    check(hi, 0);
    sda_drv <= 1'b0;
    wait_n(12);
    scl_in <= 1'b0;
    wait_n(3);
    i2c_byte({7'(RTPCS_I2C_ADDR), 1'b0});
    i2c_byte(8'h00);
    for (int i = 0; i < 24; i++) i2c_byte(img(1'b1, i));
    sda_drv <= 1'b0;
    wait_n(12);
    scl_in <= 1'b1;
    wait_n(12);
    sda_drv <= 1'b1;
    wait_n(300);
    check_img(1'b1, 1'b0);
    check_img(1'b0, 1'b1);
    boot();
    check_img(1'b1, 1'b1);
    check_img(1'b1, 1'b0);
    test_done();
  end
  initial begin
    #2_000_000;
    mismatches++;
    test_done();
  end
endmodule
bind rtpcs_top rtpcs_chk #(.NRAIL(NRAIL)) i_chk (.core_clk_in, .rst_b_in, .wb_cyc_in,
  .wb_stb_in, .wb_we_in, .wb_adr_in, .wb_dat_out, .wb_ack_out, .scl_in, .sda_oe_b_out,
  .nv_rdy_in, .nv_req_out, .nv_we_out, .nv_addr_out, .nv_wdata_out, .trim_pwm_out);
